// file: gpw_pkg.sv
// Package: register map, reset values and helpers for the GPIO port block
`default_nettype none
package gpw_pkg;
    localparam int PORT_W = 8;
    localparam int PORT_D_W = 7;
    localparam logic [7:0] ADDR_PA_DATA = 8'h00;
    localparam logic [7:0] ADDR_PA_DIR = 8'h01;
    localparam logic [7:0] ADDR_PA_PU = 8'h02;
    localparam logic [7:0] ADDR_PA_WAKE = 8'h03;
    localparam logic [7:0] ADDR_PB_DATA = 8'h04;
    localparam logic [7:0] ADDR_PB_DIR = 8'h05;
    localparam logic [7:0] ADDR_PB_PU = 8'h06;
    localparam logic [7:0] ADDR_PC_DATA = 8'h08;
    localparam logic [7:0] ADDR_PC_DIR = 8'h09;
    localparam logic [7:0] ADDR_PC_PU = 8'h0a;
    localparam logic [7:0] ADDR_PD_DATA = 8'h0c;
    localparam logic [7:0] ADDR_PD_DIR = 8'h0d;
    localparam logic [7:0] ADDR_PD_PU = 8'h0e;
    localparam logic [7:0] RST_DATA = 8'hff;
    localparam logic [7:0] RST_DIR = 8'hff;
    localparam logic [7:0] RST_PU = 8'h00;
    localparam logic [7:0] RST_WAKE = 8'h00;
    localparam logic [7:0] RST_RDATA = 8'h00;

    // Inputs read the pin, outputs read the latch
    function automatic logic [7:0] gpw_read(input logic [7:0] dir,
                                            input logic [7:0] latch,
                                            input logic [7:0] pin);
        gpw_read = (dir & pin) | (~dir & latch);
    endfunction : gpw_read
endpackage : gpw_pkg
`default_nettype wire

// file: gpw_port.sv
// One I/O port: output latch, direction, pull-high and pin drive
`timescale 1ns/10ps
`default_nettype none
module gpw_port
    import gpw_pkg::*;
#(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register writes
    input wire logic wr_data,
    input wire logic wr_dir,
    input wire logic wr_pu,
    input wire logic [W-1:0] wdata,
    // Register state
    output logic [W-1:0] latch_q,
    output logic [W-1:0] dir_q,
    output logic [W-1:0] pu_q,
    // Pin side
    output logic [W-1:0] pin_out_q,
    output logic [W-1:0] pin_oe_q,
    output logic [W-1:0] pull_en_q
);
    logic [W-1:0] latch_d;
    logic [W-1:0] dir_d;
    logic [W-1:0] pu_d;

    always_comb begin
        latch_d = latch_q;
        dir_d = dir_q;
        pu_d = pu_q;
        if (wr_data) begin
            latch_d = wdata;
        end
        if (wr_dir) begin
            dir_d = wdata;
        end
        if (wr_pu) begin
            pu_d = wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_q <= RST_DATA[W-1:0];
            dir_q <= RST_DIR[W-1:0];
            pu_q <= RST_PU[W-1:0];
            pin_out_q <= RST_DATA[W-1:0];
            pin_oe_q <= '0;
            pull_en_q <= '0;
        end else begin
            latch_q <= latch_d;
            dir_q <= dir_d;
            pu_q <= pu_d;
            pin_out_q <= latch_d;
            pin_oe_q <= ~dir_d;
            // Pull-high only on inputs; it would fight a CMOS drive
            pull_en_q <= pu_d & dir_d;
        end
    end
endmodule : gpw_port
`default_nettype wire

// file: gpw_gpio.sv
// Top of the GPIO block: four ports, register access and port A wake-up
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - Four bidirectional ports A to D, one data bit per pin, each usable as input or output.
// - A read of an input pin samples the pin directly with no input latch, at the read strobe.
// - A written data value sits in an output latch until the data register is written again.
// - Each pin has a pull-high bit where 1 enables and 0 disables the weak pull-high.
// - The pull-high acts only while the pin is an input, otherwise it stays off.
// - A falling edge on a wake-enabled port A pin wakes the controller from IDLE or SLEEP.
// - Each port A pin has its own wake enable bit, 1 enabling and 0 disabling.
// - Wake enables act only on input pins while the controller is in a low-power mode.
// - Bit 7 of the port D data, direction and pull-high registers reads as zero.
// - A direction bit of 1 makes the pin an input and 0 a CMOS output from the latch.
// - Reading the data register of an output pin returns the latch, not the pin level.
module gpw_gpio
    import gpw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data memory access
    input wire logic [7:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata_q,
    // Port A pins
    input wire logic [7:0] pa_in,
    output logic [7:0] pa_out_q,
    output logic [7:0] pa_oe_q,
    output logic [7:0] pa_pull_q,
    // Port B pins
    input wire logic [7:0] pb_in,
    output logic [7:0] pb_out_q,
    output logic [7:0] pb_oe_q,
    output logic [7:0] pb_pull_q,
    // Port C pins
    input wire logic [7:0] pc_in,
    output logic [7:0] pc_out_q,
    output logic [7:0] pc_oe_q,
    output logic [7:0] pc_pull_q,
    // Port D pins
    input wire logic [6:0] pd_in,
    output logic [6:0] pd_out_q,
    output logic [6:0] pd_oe_q,
    output logic [6:0] pd_pull_q,
    // Power management
    input wire logic low_power,
    output logic wake_req_q
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] a_lat, a_dir, a_pu;
    logic [7:0] b_lat, b_dir, b_pu;
    logic [7:0] c_lat, c_dir, c_pu;
    logic [6:0] d_lat, d_dir, d_pu;
    logic [7:0] wake_en_q, wake_en_d;
    logic [7:0] pa_prev_q, pa_prev_d;
    logic wake_req_d;
    logic [7:0] rdata_d;

    // Same port module for all four; D is one pin narrower
    gpw_port #(.W(PORT_W)) u_pa (
        .clk(clk), .rst_n(rst_n),
        .wr_data(wr_en && addr == ADDR_PA_DATA),
        .wr_dir(wr_en && addr == ADDR_PA_DIR),
        .wr_pu(wr_en && addr == ADDR_PA_PU),
        .wdata(wdata),
        .latch_q(a_lat), .dir_q(a_dir), .pu_q(a_pu),
        .pin_out_q(pa_out_q), .pin_oe_q(pa_oe_q), .pull_en_q(pa_pull_q)
    );
    gpw_port #(.W(PORT_W)) u_pb (
        .clk(clk), .rst_n(rst_n),
        .wr_data(wr_en && addr == ADDR_PB_DATA),
        .wr_dir(wr_en && addr == ADDR_PB_DIR),
        .wr_pu(wr_en && addr == ADDR_PB_PU),
        .wdata(wdata),
        .latch_q(b_lat), .dir_q(b_dir), .pu_q(b_pu),
        .pin_out_q(pb_out_q), .pin_oe_q(pb_oe_q), .pull_en_q(pb_pull_q)
    );
    gpw_port #(.W(PORT_W)) u_pc (
        .clk(clk), .rst_n(rst_n),
        .wr_data(wr_en && addr == ADDR_PC_DATA),
        .wr_dir(wr_en && addr == ADDR_PC_DIR),
        .wr_pu(wr_en && addr == ADDR_PC_PU),
        .wdata(wdata),
        .latch_q(c_lat), .dir_q(c_dir), .pu_q(c_pu),
        .pin_out_q(pc_out_q), .pin_oe_q(pc_oe_q), .pull_en_q(pc_pull_q)
    );
    gpw_port #(.W(PORT_D_W)) u_pd (
        .clk(clk), .rst_n(rst_n),
        .wr_data(wr_en && addr == ADDR_PD_DATA),
        .wr_dir(wr_en && addr == ADDR_PD_DIR),
        .wr_pu(wr_en && addr == ADDR_PD_PU),
        .wdata(wdata[6:0]),
        .latch_q(d_lat), .dir_q(d_dir), .pu_q(d_pu),
        .pin_out_q(pd_out_q), .pin_oe_q(pd_oe_q), .pull_en_q(pd_pull_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read path: input pins sampled live at the read strobe, output pins read the latch
    always_comb begin
        rdata_d = rdata_q;
        if (rd_en) begin
            case (addr)
                ADDR_PA_DATA: rdata_d = gpw_read(a_dir, a_lat, pa_in);
                ADDR_PA_DIR: rdata_d = a_dir;
                ADDR_PA_PU: rdata_d = a_pu;
                ADDR_PA_WAKE: rdata_d = wake_en_q;
                ADDR_PB_DATA: rdata_d = gpw_read(b_dir, b_lat, pb_in);
                ADDR_PB_DIR: rdata_d = b_dir;
                ADDR_PB_PU: rdata_d = b_pu;
                ADDR_PC_DATA: rdata_d = gpw_read(c_dir, c_lat, pc_in);
                ADDR_PC_DIR: rdata_d = c_dir;
                ADDR_PC_PU: rdata_d = c_pu;
                ADDR_PD_DATA: rdata_d = gpw_read({1'b0, d_dir},
                    {1'b0, d_lat}, {1'b0, pd_in}) & 8'h7f;
                ADDR_PD_DIR: rdata_d = {1'b0, d_dir};
                ADDR_PD_PU: rdata_d = {1'b0, d_pu};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake-up on port A falling edges
    always_comb begin
        wake_en_d = wake_en_q;
        if (wr_en && addr == ADDR_PA_WAKE) begin
            wake_en_d = wdata;
        end
        pa_prev_d = pa_in;
        // Output pins excluded so own writes cannot wake the core
        wake_req_d = low_power &&
            |(pa_prev_q & ~pa_in & wake_en_q & a_dir);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wake_en_q <= RST_WAKE;
            pa_prev_q <= RST_DATA;
            wake_req_q <= 1'b0;
            rdata_q <= RST_RDATA;
        end else begin
            wake_en_q <= wake_en_d;
            pa_prev_q <= pa_prev_d;
            wake_req_q <= wake_req_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    latch_hold_a: assert property (
        !(wr_en && addr == ADDR_PB_DATA) |=> pb_out_q == $past(pb_out_q))
        else $error("port B latch changed without a write");
    latch_write_a: assert property (
        wr_en && addr == ADDR_PC_DATA |=> pc_out_q == $past(wdata))
        else $error("port C latch missed a write");
    dir_drive_a: assert property (
        wr_en && addr == ADDR_PA_DIR |=> pa_oe_q == ~$past(wdata))
        else $error("port A drive does not follow direction");
    pull_gate_a: assert property (
        (pa_pull_q & pa_oe_q) == 8'h00 && (pb_pull_q & pb_oe_q) == 8'h00)
        else $error("pull-high on a driven pin");
    pull_write_a: assert property (
        wr_en && addr == ADDR_PB_PU && wdata == 8'hff
        && !(wr_en && addr == ADDR_PB_DIR) ##0 b_dir == 8'hff
        |=> pb_pull_q == 8'hff)
        else $error("pull-high not enabled on inputs");
    pin_read_a: assert property (
        rd_en && addr == ADDR_PA_DATA && a_dir == 8'hff
        |=> rdata_q == $past(pa_in))
        else $error("input read does not show pin level");
    latch_read_a: assert property (
        rd_en && addr == ADDR_PC_DATA && c_dir == 8'h00
        |=> rdata_q == $past(c_lat))
        else $error("output read does not show latch");
    pd_top_a: assert property (
        rd_en && (addr == ADDR_PD_DATA || addr == ADDR_PD_DIR
        || addr == ADDR_PD_PU) |=> rdata_q[7] == 1'b0)
        else $error("port D bit 7 not zero");
    wake_edge_a: assert property (
        low_power && |($past(pa_in) & ~pa_in & wake_en_q & a_dir)
        |=> wake_req_q)
        else $error("falling edge did not wake");
    wake_awake_a: assert property (
        !$past(low_power) |-> !wake_req_q)
        else $error("wake request outside low power");

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs are registered, so the write checks here look one cycle after the write
    pull_set_a: assert property (
        wr_en && addr == ADDR_PA_PU |=> pa_pull_q == ($past(wdata) & a_dir))
        else $error("port A pull-high does not follow its write");
    pull_gate_cd_a: assert property (
        (pc_pull_q & pc_oe_q) == 8'h00 && (pd_pull_q & pd_oe_q) == 7'h00)
        else $error("pull-high on a driven pin of port C or D");
    wake_write_a: assert property (
        wr_en && addr == ADDR_PA_WAKE |=> wake_en_q == $past(wdata))
        else $error("wake enable missed a write");
    wake_masked_a: assert property (
        (wake_en_q & a_dir) == 8'h00 |=> !wake_req_q)
        else $error("wake request with no enabled input pin");
    pa_latch_a: assert property (
        wr_en && addr == ADDR_PA_DATA |=> pa_out_q == $past(wdata))
        else $error("port A latch missed a write");
    pd_latch_a: assert property (
        wr_en && addr == ADDR_PD_DATA |=> pd_out_q == $past(wdata[6:0]))
        else $error("port D latch missed a write");
    pb_drive_a: assert property (
        wr_en && addr == ADDR_PB_DIR |=> pb_oe_q == ~$past(wdata))
        else $error("port B drive does not follow direction");
    pd_drive_a: assert property (
        wr_en && addr == ADDR_PD_DIR |=> pd_oe_q == ~$past(wdata[6:0]))
        else $error("port D drive does not follow direction");
    // Read data must stand until the next read strobe
    rdata_hold_a: assert property (
        !rd_en |=> rdata_q == $past(rdata_q))
        else $error("read data changed without a read");
    unmapped_read_a: assert property (
        rd_en && addr == 8'h07 |=> rdata_q == 8'h00)
        else $error("unmapped read did not return zero");
endmodule : gpw_gpio
`default_nettype wire

// file: gpw_pin_model.sv
// Pin model: outside drivers, pull-highs and floating lines on one port
`timescale 1ns/10ps
`default_nettype none
module gpw_pin_model #(
    parameter int W = 8
) (
    // Clock
    input wire logic clk,
    // Device side
    input wire logic [W-1:0] out_q,
    input wire logic [W-1:0] oe_q,
    input wire logic [W-1:0] pull_q,
    // Outside drivers, changed only just after an edge
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    // Level seen by the device
    output logic [W-1:0] pin_lvl
);
    logic [W-1:0] flt_q = '0;
    // Open lines toggle so a stale level can never pass for a match
    always_ff @(posedge clk) begin
        flt_q <= ~flt_q;
    end
    always_comb begin
        pin_lvl = (oe_q & out_q)
            | (~oe_q & ext_en & ext_val)
            | (~oe_q & ~ext_en & pull_q)
            | (~oe_q & ~ext_en & ~pull_q & flt_q);
    end
endmodule : gpw_pin_model
`default_nettype wire

// file: tb.sv
// Testbench: register table, pin levels, wake-up and reset
`timescale 1ns/10ps
`default_nettype none
module tb
    import gpw_pkg::*;
;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;}
        gpw_row_t;
    logic clk, rst_n, wr_en, rd_en, low_power, wake_req_q;
    logic [7:0] addr, wdata, rdata_q, ext_en, ext_val;
    logic [7:0] pa_in, pa_out_q, pa_oe_q, pa_pull_q;
    logic [7:0] pb_in, pb_out_q, pb_oe_q, pb_pull_q;
    logic [7:0] pc_in, pc_out_q, pc_oe_q, pc_pull_q;
    logic [6:0] pd_in, pd_out_q, pd_oe_q, pd_pull_q;
    int err_total, n_compared, cyc;
    gpw_row_t rows [17] = '{
        '{ADDR_PA_DIR, 8'h00, 8'h00}, '{ADDR_PA_DATA, 8'ha5, 8'ha5},
        '{ADDR_PA_PU, 8'h3c, 8'h3c}, '{ADDR_PA_WAKE, 8'h81, 8'h81},
        '{ADDR_PB_DIR, 8'h00, 8'h00}, '{ADDR_PB_DATA, 8'h5a, 8'h5a},
        '{ADDR_PB_PU, 8'hc3, 8'hc3}, '{ADDR_PC_DIR, 8'h00, 8'h00},
        '{ADDR_PC_DATA, 8'h96, 8'h96}, '{ADDR_PC_PU, 8'h0f, 8'h0f},
        '{ADDR_PD_DIR, 8'h00, 8'h00}, '{ADDR_PD_DATA, 8'hff, 8'h7f},
        '{ADDR_PD_PU, 8'hff, 8'h7f}, '{ADDR_PD_DIR, 8'h80, 8'h00},
        '{8'h07, 8'h55, 8'h00}, '{8'h0b, 8'haa, 8'h00},
        '{ADDR_PA_DATA, 8'h3c, 8'h3c}};
    gpw_gpio i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en),
        .rd_en(rd_en), .wdata(wdata), .rdata_q(rdata_q), .pa_in(pa_in),
        .pa_out_q(pa_out_q), .pa_oe_q(pa_oe_q), .pa_pull_q(pa_pull_q),
        .pb_in(pb_in), .pb_out_q(pb_out_q), .pb_oe_q(pb_oe_q),
        .pb_pull_q(pb_pull_q), .pc_in(pc_in), .pc_out_q(pc_out_q),
        .pc_oe_q(pc_oe_q), .pc_pull_q(pc_pull_q), .pd_in(pd_in),
        .pd_out_q(pd_out_q), .pd_oe_q(pd_oe_q), .pd_pull_q(pd_pull_q),
        .low_power(low_power), .wake_req_q(wake_req_q));
    gpw_pin_model #(.W(8)) i_pin_a (.clk(clk), .out_q(pa_out_q),
        .oe_q(pa_oe_q), .pull_q(pa_pull_q), .ext_en(ext_en),
        .ext_val(ext_val), .pin_lvl(pa_in));
    // Outside drivers shared by all ports; outputs ignore them
    gpw_pin_model #(.W(8)) i_pin_b (.clk(clk), .out_q(pb_out_q),
        .oe_q(pb_oe_q), .pull_q(pb_pull_q), .ext_en(ext_en),
        .ext_val(ext_val), .pin_lvl(pb_in));
    gpw_pin_model #(.W(8)) i_pin_c (.clk(clk), .out_q(pc_out_q),
        .oe_q(pc_oe_q), .pull_q(pc_pull_q), .ext_en(ext_en),
        .ext_val(ext_val), .pin_lvl(pc_in));
    gpw_pin_model #(.W(7)) i_pin_d (.clk(clk), .out_q(pd_out_q),
        .oe_q(pd_oe_q), .pull_q(pd_pull_q), .ext_en(ext_en[6:0]),
        .ext_val(ext_val[6:0]), .pin_lvl(pd_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(rdata_q, e);
    endtask : rd
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Whole run needs about 115 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        {rst_n, wr_en, rd_en, low_power, addr, wdata} = '0;
        {ext_en, ext_val, err_total, n_compared} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        chk(pa_out_q, 8'h3c);
        chk(pa_oe_q, 8'hff);
        chk(pa_pull_q, 8'h00);
        chk({1'b0, pd_out_q}, 8'h7f);
        chk(pc_pull_q, 8'h00);
        chk(pb_out_q, 8'h5a);
        chk(pc_out_q, 8'h96);
        chk({1'b0, pd_oe_q}, 8'h7f);
        @(posedge clk);
        ext_en <= 8'hff;
        ext_val <= 8'hc3;
        wr(ADDR_PA_DIR, 8'hf0);
        chk(pa_oe_q, 8'h0f);
        chk(pa_pull_q, 8'h30);
        rd(ADDR_PA_DATA, 8'hcc);
        @(posedge clk);
        ext_val <= 8'h5a;
        rd(ADDR_PA_DATA, 8'h5c);
        wr(ADDR_PA_DIR, 8'hff);
        @(posedge clk);
        ext_val <= 8'hff;
        low_power <= 1'b1;
        repeat (2) @(posedge clk);
        ext_val <= 8'hfe;
        @(posedge clk);
        #1 chk({7'h00, wake_req_q}, 8'h01);
        @(posedge clk);
        ext_val <= 8'hfc;
        #1 chk({7'h00, wake_req_q}, 8'h00);
        @(posedge clk);
        low_power <= 1'b0;
        ext_val <= 8'h7c;
        #1 chk({7'h00, wake_req_q}, 8'h00);
        @(posedge clk);
        #1 chk({7'h00, wake_req_q}, 8'h00);
        rd(ADDR_PA_DATA, 8'h7c);
        wr(ADDR_PB_DIR, 8'hff);
        chk(pb_oe_q, 8'h00);
        wr(ADDR_PB_PU, 8'hff);
        chk(pb_pull_q, 8'hff);
        rd(ADDR_PB_DATA, 8'h7c);
        wr(ADDR_PC_DIR, 8'hff);
        chk(pc_oe_q, 8'h00);
        rd(ADDR_PC_DATA, 8'h7c);
        wr(ADDR_PD_DIR, 8'hff);
        chk({1'b0, pd_pull_q}, 8'h7f);
        rd(ADDR_PD_DATA, 8'h7c);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk(pa_out_q, 8'hff);
        chk(pa_oe_q | pa_pull_q | rdata_q, 8'h00);
        rd(ADDR_PA_WAKE, 8'h00);
        rd(ADDR_PD_DIR, 8'h7f);
        rd(ADDR_PB_PU, 8'h00);
        stop_test();
    end
endmodule : tb
`default_nettype wire
